// ---- rtl/idw_defs.svh ----
/*
  constants for the identification words 80..88 and the host's register map.
  assumes nothing; included by bare name.
*/
`ifndef IDW_DEFS_SVH
`define IDW_DEFS_SVH
// word indices inside the identification block
`define W_MAJOR   8'd80
`define W_MINOR   8'd81
`define W_SUPP1   8'd82
`define W_SUPP2   8'd83
`define W_SUPPX   8'd84
`define W_EN1     8'd85
`define W_EN2     8'd86
`define W_DEFLT   8'd87
`define W_NEXT    8'd88
`define W_FIRST   8'd80
// special word values
`define WORD_BLANK_LO 16'h0000
`define WORD_BLANK_HI 16'hffff
`define VALID_MARK    16'h4000
// major version word: revision 2..5 bits start here
`define MAJ_REV_LSB 2
// first supported / first enabled word fields
`define F1_NOP   14
`define F1_BUFRD 13
`define F1_BUFWR 12
`define F1_PROT  10
`define F1_DRST  9
`define F1_SVC   8
`define F1_REL   7
`define F1_LOOK  6
`define F1_WC    5
`define F1_PKT   4
`define F1_PM    3
`define F1_RM    2
`define F1_SEC   1
`define F1_SMON  0
// second supported / second enabled word fields
`define F2_SPIN  6
`define F2_PUIS  5
`define F2_RMSN  4
`define F2_APM   3
`define F2_CF    2
`define F2_QDMA  1
`define F2_UCODE 0
// host register map (byte addresses)
`define REG_CTRL 4'h0
`define REG_STAT 4'h4
`define REG_DATA 4'h8
// control fields
`define CTRL_IDX_LSB 0
`define CTRL_START   8
// status fields
`define ST_BUSY    0
`define ST_DONE    1
`define ST_VER_ABS 2
`define ST_SUP_ABS 3
`define ST_EXT_ABS 4
`define ST_EN_ABS  5
`define ST_DEF_ABS 6
// reset values
`define RST_WORD 16'h0000
`define RST_BUS  32'h0000_0000
`endif

// ---- rtl/idw_pkg.sv ----
/*
  types shared by both ends of the identification word link.
  assumes the defines of idw_defs.svh for the field layout.
*/
package idw_pkg;
  // capability straps, fixed for the life of the device
  typedef struct packed {
    logic nop, bufRead, bufWrite, protArea, devReset, serviceIrq, releaseIrq;
    logic lookAhead, writeCache, packetSet, powerMgmt, removable, selfMon;
    logic spinupReq, puis, rmsn, apm, compact_flash_feature_set, queuedDma;
    logic microcode;
  } supp_t;
  // live enable state of switchable features
  typedef struct packed {
    logic serviceIrq, releaseIrq, lookAhead, writeCache, security, selfMon;
    logic puis, rmsn, apm;
  } en_t;
  // device end state
  typedef struct packed {
    logic        loaded;
    logic        verOn;
    logic [3:0]  verBits;
    logic [15:0] minor;
    logic        suppOn;
    supp_t       supp;
    logic        enOn;
    en_t         en;
    logic        rdValid;
    logic [15:0] rdData;
  } dev_state_t;
  // host transfer machine
  typedef enum logic [1:0] {
    H_IDLE = 2'b01,
    H_WAIT = 2'b10
  } host_fsm_t;
  // host end state
  typedef struct packed {
    host_fsm_t         fsm;
    logic              rdReq;
    logic [7:0]        wordIdx;
    logic              done;
    logic [15:0]       lastWord;
    logic [7:0][15:0]  words;
    logic [7:0]        seen;
    logic              waitReq;
    logic [31:0]       readData;
  } host_state_t;
endpackage

// ---- rtl/idw_if.sv ----
/*
  link between the identification word source and its reader.
  assumes both ends run on the same ref_clk.
*/
`timescale 1ns/1ps
interface idw_if;
  logic        rdReq;    // host asks for a word, level
  logic [7:0]  wordIdx;  // word number asked for
  logic        rdValid;  // device answer, one-cycle pulse
  logic [15:0] rdData;   // answered word
  // documented device end
  modport device (input rdReq, input wordIdx, output rdValid, output rdData);
  // reading party end
  modport host (output rdReq, output wordIdx, input rdValid, input rdData);
endinterface

// ---- rtl/word_blank_check.sv ----
/*
  flags a word that carries no report: all zeros or all ones.
  assumes a plain combinational context.
*/
`timescale 1ns/1ps
`include "idw_defs.svh"
module word_blank_check #(
  parameter int W = 16
) (
  // word under test
  input  wire logic [W-1:0] word,
  // result
  output logic              blank
);
  // both encodings mean the same: nothing reported
  assign blank = (word == W'(`WORD_BLANK_LO)) || (word == W'(`WORD_BLANK_HI));
endmodule

// ---- rtl/id_words_host.sv ----
/*
  host end: fetches identification words on software request and
  decides which reports are absent.
  assumes an Avalon-MM master on the register side and the device end on the link.
*/
`timescale 1ns/1ps
`include "idw_defs.svh"
module id_words_host (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // avalon-mm slave
  input  wire logic [3:0]  avAddress,
  input  wire logic        avRead,
  input  wire logic        avWrite,
  input  wire logic [31:0] avWriteData,
  input  wire logic [3:0]  avByteEnable,
  output logic [31:0]      avReadData,
  output logic             avWaitRequest,
  // link
  idw_if.host              link
);
  idw_pkg::host_state_t s_q, s_d;  // whole state
  logic [7:0]           blank;     // per-word no-report flags
  logic                 verAbs, supAbs, extAbs, enAbs;

  // one checker per stored word 80..87
  for (genvar i = 0; i < 8; i++) begin : g_blank
    word_blank_check #(.W(16)) word_blank_check_inst (
      .word  (s_q.words[i]),
      .blank (blank[i])
    );
  end

  // absence only counts once every word of the group was fetched
  // supported absent
  assign supAbs = &(s_q.seen[3:2] & blank[3:2]);
  assign extAbs = &(s_q.seen[4:2] & blank[4:2]);
  assign enAbs  = &(s_q.seen[7:5] & blank[7:5]);
  assign verAbs = s_q.seen[0] & s_q.seen[1] & blank[0] & blank[1];

  // next state: bus slave, transfer machine, word capture
  always_comb begin
    s_d = s_q;
    // wait is high except for the one answer cycle
    s_d.waitReq = 1'b1;
    if ((avRead || avWrite) && s_q.waitReq) begin
      s_d.waitReq  = 1'b0;
      s_d.readData = `RST_BUS;
      unique case (avAddress)
        `REG_CTRL: begin
          s_d.readData[`CTRL_IDX_LSB +: 8] = s_q.wordIdx;
        end
        `REG_STAT: begin
          s_d.readData[`ST_BUSY]    = (s_q.fsm == idw_pkg::H_WAIT);
          s_d.readData[`ST_DONE]    = s_q.done;
          s_d.readData[`ST_VER_ABS] = verAbs;
          s_d.readData[`ST_SUP_ABS] = supAbs;
          s_d.readData[`ST_EXT_ABS] = extAbs;
          s_d.readData[`ST_EN_ABS]  = enAbs;
          s_d.readData[`ST_DEF_ABS] = enAbs;
        end
        `REG_DATA: begin
          s_d.readData[15:0] = s_q.lastWord;
        end
        default: begin
          // unmapped reads return zero
          s_d.readData = `RST_BUS;
        end
      endcase
    end
    // a write takes effect at the edge that ends its wait
    if (avWrite && !s_q.waitReq && avAddress == `REG_CTRL && s_q.fsm == idw_pkg::H_IDLE) begin
      if (avByteEnable[0]) begin
        s_d.wordIdx = avWriteData[`CTRL_IDX_LSB +: 8];
      end
      if (avByteEnable[1] && avWriteData[`CTRL_START]) begin
        s_d.fsm   = idw_pkg::H_WAIT;
        s_d.rdReq = 1'b1;
        s_d.done  = 1'b0;
      end
    end
    // transfer machine
    unique case (s_q.fsm)
      idw_pkg::H_IDLE: begin
        s_d.rdReq = s_d.rdReq;
      end
      idw_pkg::H_WAIT: begin
        if (link.rdValid) begin
          s_d.rdReq    = 1'b0;
          s_d.fsm      = idw_pkg::H_IDLE;
          s_d.done     = 1'b1;
          s_d.lastWord = link.rdData;
          if (s_q.wordIdx >= `W_FIRST && s_q.wordIdx < `W_NEXT) begin
            s_d.words[3'(s_q.wordIdx - `W_FIRST)] = link.rdData;
            s_d.seen[3'(s_q.wordIdx - `W_FIRST)]  = 1'b1;
          end
        end
      end
    endcase
  end

  // register the state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q          <= '0;
      s_q.fsm      <= idw_pkg::H_IDLE;
      s_q.wordIdx  <= `W_FIRST;
      s_q.waitReq  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign avReadData    = s_q.readData;
  assign avWaitRequest = s_q.waitReq;
  assign link.rdReq    = s_q.rdReq;
  assign link.wordIdx  = s_q.wordIdx;
endmodule

// ---- rtl/id_words_device.sv ----
/*
  device end: produces identification words 80..88 on request.
  assumes straps are stable at reset release and the host holds a
  request until it sees the answer.
*/
// Contract
// - blank version words mean not reported
// - major bits 5..2 flag revisions supported
// - major bits 14..6 read zero
// - minor code passed through unchanged
// - words 82,83 blank mean no support report
// - first supported word capability bits
// - write cache, packet, self-monitor bits
// - words 83,84,87 carry valid mark
// - second supported word high bits
// - second supported word low bits
// - extension blank means absent, low reserved
// - enabled words blank means absent
// - first enabled word live state bits
// - security, self-monitor, support mirror bits
// - second enabled word bits
// - default word reserved below mark
// - word 88 top bits zero
`timescale 1ns/1ps
`include "idw_defs.svh"
module id_words_device (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // fixed identity, sampled once after reset
  input  wire logic        reportVersion,
  input  wire logic [3:0]  versionSupport,
  input  wire logic [15:0] minorVersion,
  input  wire logic        reportSupport,
  input  wire idw_pkg::supp_t support,
  // live feature state
  input  wire logic        reportEnabled,
  input  wire idw_pkg::en_t enabled,
  // link
  idw_if.device            link
);
  idw_pkg::dev_state_t s_q, s_d;  // whole state

  // builds one word from the held state; unknown indices read zero
  function automatic logic [15:0] build_word(
    input logic [7:0]          idx,
    input idw_pkg::dev_state_t st
  );
    logic [15:0] w;
    w = `RST_WORD;
    unique case (idx)
      `W_MAJOR: begin
        if (st.verOn) begin
          w[`MAJ_REV_LSB +: 4] = st.verBits;
          w[15:`MAJ_REV_LSB+4] = '0;
        end
      end
      `W_MINOR: begin
        if (st.verOn) begin
          w = st.minor;
        end
      end
      `W_SUPP1: begin
        if (st.suppOn) begin
          w[`F1_NOP]   = st.supp.nop;
          w[`F1_BUFRD] = st.supp.bufRead;
          w[`F1_BUFWR] = st.supp.bufWrite;
          w[`F1_PROT]  = st.supp.protArea;
          w[`F1_DRST]  = st.supp.devReset;
          w[`F1_SVC]   = st.supp.serviceIrq;
          w[`F1_REL]   = st.supp.releaseIrq;
          w[`F1_LOOK]  = st.supp.lookAhead;
          w[`F1_WC]    = st.supp.writeCache;
          w[`F1_PKT]   = st.supp.packetSet;
          w[`F1_SMON]  = st.supp.selfMon;
        end
      end
      `W_SUPP2: begin
        if (st.suppOn) begin
          w = `VALID_MARK;
          w[`F2_SPIN]  = st.supp.spinupReq;
          w[`F2_PUIS]  = st.supp.puis;
          w[`F2_RMSN]  = st.supp.rmsn;
          w[`F2_APM]   = st.supp.apm;
          w[`F2_CF]    = st.supp.compact_flash_feature_set;
          w[`F2_QDMA]  = st.supp.queuedDma;
          w[`F2_UCODE] = st.supp.microcode;
        end
      end
      `W_SUPPX: begin
        if (st.suppOn) begin
          w = `VALID_MARK;
        end
      end
      `W_EN1: begin
        if (st.enOn) begin
          w[`F1_NOP]   = st.supp.nop;
          w[`F1_BUFRD] = st.supp.bufRead;
          w[`F1_BUFWR] = st.supp.bufWrite;
          w[`F1_PROT]  = st.supp.protArea;
          w[`F1_DRST]  = st.supp.devReset;
          w[`F1_SVC]   = st.en.serviceIrq;
          w[`F1_REL]   = st.en.releaseIrq;
          w[`F1_LOOK]  = st.en.lookAhead;
          w[`F1_WC]    = st.en.writeCache;
          w[`F1_PKT]   = st.supp.packetSet;
          w[`F1_PM]    = st.supp.powerMgmt;
          w[`F1_RM]    = st.supp.removable;
          w[`F1_SEC]   = st.en.security;
          w[`F1_SMON]  = st.en.selfMon;
        end
      end
      `W_EN2: begin
        if (st.enOn) begin
          w[`F2_SPIN]  = st.supp.spinupReq;
          w[`F2_PUIS]  = st.en.puis;
          w[`F2_RMSN]  = st.en.rmsn;
          w[`F2_APM]   = st.en.apm;
          w[`F2_CF]    = st.supp.compact_flash_feature_set;
          w[`F2_QDMA]  = st.supp.queuedDma;
          w[`F2_UCODE] = st.supp.microcode;
        end
      end
      `W_DEFLT: begin
        if (st.enOn) begin
          w = `VALID_MARK;
        end
      end
      `W_NEXT: begin
        // top bits zero; rest not produced here
        w = `RST_WORD;
      end
      default: begin
        // outside this block's range
        w = `RST_WORD;
      end
    endcase
    return w;
  endfunction

  // next state
  always_comb begin
    s_d = s_q;
    // fixed words caught once, then frozen
    if (!s_q.loaded) begin
      s_d.loaded  = 1'b1;
      s_d.verOn   = reportVersion;
      s_d.verBits = versionSupport;
      s_d.minor   = minorVersion;
      s_d.suppOn  = reportSupport;
      s_d.supp    = support;
    end
    s_d.enOn = reportEnabled;
    s_d.en   = enabled;
    // answer pulse lasts one cycle; a held request is not answered in the cycle right after its answer
    s_d.rdValid = 1'b0;
    if (s_q.loaded && link.rdReq && !s_q.rdValid) begin
      s_d.rdValid = 1'b1;
      s_d.rdData  = build_word(link.wordIdx, s_q);
    end
  end

  // register the state; straps are taken after release, not under reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // link outputs straight from flops
  assign link.rdValid = s_q.rdValid;
  assign link.rdData  = s_q.rdData;
endmodule

// ---- verification/id_words_asserts.sv ----
/*
  checker for the identification word link between the two ends.
  assumes it sits beside the interface, one clock, synchronous reset.
*/
`timescale 1ns/1ps
`include "idw_defs.svh"
module id_words_asserts (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // link signals
  input wire logic        rdReq,
  input wire logic [7:0]  wordIdx,
  input wire logic        rdValid,
  input wire logic [15:0] rdData
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // index of the request taken at the previous edge
  logic [7:0] takenIdx;
  // the answer belongs to the index taken one edge earlier, not the live one
  always_ff @(posedge ref_clk) begin
    takenIdx <= wordIdx;
  end
  a_answer_pulse: assert property (rdValid |=> !rdValid)
    else $error("answer strobe longer than one cycle");
  a_answer_cause: assert property (rdValid |-> $past(rdReq))
    else $error("answer without request");
  a_answer_bound: assert property ($rose(rdReq) |-> ##[1:4] rdValid)
    else $error("request not answered in time");
  a_data_hold: assert property (!rdValid |-> $stable(rdData))
    else $error("answer data moved between answers");
  a_major_zero: assert property (rdValid && takenIdx == `W_MAJOR
    |-> rdData[15:6] == 10'h0 && rdData[1:0] == 2'h0)
    else $error("major word reserved bits set");
  a_supp1_obsolete: assert property (rdValid && takenIdx == `W_SUPP1
    |-> !rdData[15] && !rdData[11] && rdData[3:1] == 3'h0)
    else $error("first supported word obsolete bits set");
  a_supp2_mark: assert property (rdValid && takenIdx == `W_SUPP2
    |-> !rdData[15] && rdData[13:7] == 7'h0 && (rdData[14] || rdData == 16'h0))
    else $error("second supported word mark wrong");
  a_marked_words: assert property (rdValid
    && (takenIdx == `W_SUPPX || takenIdx == `W_DEFLT)
    |-> rdData inside {`VALID_MARK, `WORD_BLANK_LO})
    else $error("extension or default word wrong");
  a_en2_reserved: assert property (rdValid && takenIdx == `W_EN2
    |-> rdData[15:7] == 9'h0)
    else $error("second enabled word reserved bits set");
  a_next_top: assert property (rdValid && takenIdx == `W_NEXT
    |-> rdData[15:13] == 3'h0)
    else $error("word after default has top bits set");
  // main scenarios reached
  c_major: cover property (rdValid && takenIdx == `W_MAJOR);
  c_enabled: cover property (rdValid && takenIdx == `W_EN1);
  c_next: cover property (rdValid && takenIdx == `W_NEXT);
endmodule

// ---- verification/identify_version_feature_words_tb.sv ----
/*
  testbench: software fetches words 79..89 through the host registers.
  assumes both ends share ref_clk; straps are reloaded by a reset.
*/
`timescale 1ns/1ps
`include "idw_defs.svh"
module identify_version_feature_words_tb;
  logic           ref_clk;
  logic           rst;
  // avalon master side
  logic [3:0]     avAddress;
  logic           avRead;
  logic           avWrite;
  logic [31:0]    avWriteData;
  logic [31:0]    avReadData;
  logic           avWaitRequest;
  // device straps and live state
  logic           reportVersion;
  logic [3:0]     versionSupport;
  logic [15:0]    minorVersion;
  logic           reportSupport;
  idw_pkg::supp_t support;
  logic           reportEnabled;
  idw_pkg::en_t   enabled;
  // strap copies taken at reset, the words must stay frozen to these
  logic           rvS;
  logic [3:0]     vsS;
  logic [15:0]    mvS;
  logic           rsS;
  idw_pkg::supp_t spS;
  logic [31:0]    r;
  int             n_errors;
  int             total_checks;
  idw_if linkIf();
  id_words_device id_words_device_inst (.ref_clk(ref_clk), .rst(rst),
    .reportVersion(reportVersion), .versionSupport(versionSupport),
    .minorVersion(minorVersion), .reportSupport(reportSupport), .support(support),
    .reportEnabled(reportEnabled), .enabled(enabled), .link(linkIf.device));
  id_words_host id_words_host_inst (.ref_clk(ref_clk), .rst(rst), .avAddress(avAddress),
    .avRead(avRead), .avWrite(avWrite), .avWriteData(avWriteData),
    .avByteEnable(4'hf), .avReadData(avReadData), .avWaitRequest(avWaitRequest),
    .link(linkIf.host));
  id_words_asserts id_words_asserts_inst (.ref_clk(ref_clk), .rst(rst),
    .rdReq(linkIf.rdReq), .wordIdx(linkIf.wordIdx), .rdValid(linkIf.rdValid),
    .rdData(linkIf.rdData));
  // 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, want, seen);
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic avAccess(input logic wr, input logic [3:0] addr, input logic [31:0] wd);
    int n;
    @(posedge ref_clk);
    avAddress <= addr;
    avWrite <= wr;
    avRead <= !wr;
    avWriteData <= wd;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avWaitRequest !== 1'b0 && n < 50);
    r = avReadData;
    avWrite <= 1'b0;
    avRead <= 1'b0;
    // a slave that never answers ends the run
    if (avWaitRequest !== 1'b0) begin
      n_errors++;
      print_verdict();
    end
  endtask
  // expected word from the straps and the live enables
  function automatic logic [15:0] expw(input int i);
    case (i)
      80: return rvS ? {10'h0, vsS, 2'h0} : 16'h0;
      81: return rvS ? mvS : 16'h0;
      82: return rsS ? {1'b0, spS.nop, spS.bufRead, spS.bufWrite, 1'b0, spS.protArea,
        spS.devReset, spS.serviceIrq, spS.releaseIrq, spS.lookAhead, spS.writeCache,
        spS.packetSet, 3'h0, spS.selfMon} : 16'h0;
      83: return rsS ? {2'h1, 7'h0, spS.spinupReq, spS.puis, spS.rmsn, spS.apm,
        spS.compact_flash_feature_set, spS.queuedDma, spS.microcode} : 16'h0;
      84: return rsS ? 16'h4000 : 16'h0;
      85: return reportEnabled ? {1'b0, spS.nop, spS.bufRead, spS.bufWrite, 1'b0,
        spS.protArea, spS.devReset, enabled.serviceIrq, enabled.releaseIrq,
        enabled.lookAhead, enabled.writeCache, spS.packetSet, spS.powerMgmt,
        spS.removable, enabled.security, enabled.selfMon} : 16'h0;
      86: return reportEnabled ? {9'h0, spS.spinupReq, enabled.puis, enabled.rmsn,
        enabled.apm, spS.compact_flash_feature_set, spS.queuedDma, spS.microcode} : 16'h0;
      87: return reportEnabled ? 16'h4000 : 16'h0;
      default: return 16'h0;
    endcase
  endfunction
  // fetch words 79..89 and compare, then compare the status flags
  task automatic sweep(input string name, input logic [31:0] stat);
    int n;
    for (int i = 79; i <= 89; i++) begin
      avAccess(1'b1, `REG_CTRL, 32'h0000_0100 | 32'(i));
      n = 0;
      do begin
        avAccess(1'b0, `REG_STAT, 32'h0);
        n++;
      end while (r[`ST_DONE] !== 1'b1 && n < 30);
      // a fetch that never completes ends the run as a mismatch
      if (r[`ST_DONE] !== 1'b1) begin
        n_errors++;
        print_verdict();
      end
      avAccess(1'b0, `REG_DATA, 32'h0);
      chk($sformatf("word%0d", i), r & 32'hffff, {16'h0, expw(i)});
    end
    avAccess(1'b0, `REG_STAT, 32'h0);
    chk("status", r & 32'h0000_007f, stat);
    $display("test %s done", name);
  endtask
  // load new straps through a full reset
  task automatic setup(input logic rv, input logic [3:0] vs, input logic [15:0] mv,
                       input logic rs, input idw_pkg::supp_t sp);
    reportVersion <= rv;
    versionSupport <= vs;
    minorVersion <= mv;
    reportSupport <= rs;
    support <= sp;
    {rvS, vsS, mvS, rsS, spS} = {rv, vs, mv, rs, sp};
    rst <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  initial begin
    {avAddress, avRead, avWrite, avWriteData} = '0;
    {n_errors, total_checks} = '0;
    reportEnabled <= 1'b1;
    enabled <= 9'h1a5;
    setup(1'b1, 4'ha, 16'h001c, 1'b1, 20'hb6d5a);
    sweep("all reported", 32'h0000_0002);
    avAccess(1'b0, 4'hc, 32'h0);
    chk("unmapped", r, 32'h0);
    enabled <= ~enabled;
    minorVersion <= 16'h1234;
    versionSupport <= 4'h5;
    support <= ~20'hb6d5a;
    sweep("live change", 32'h0000_0002);
    reportEnabled <= 1'b0;
    sweep("enables off", 32'h0000_0062);
    setup(1'b1, 4'h0, 16'hffff, 1'b1, 20'h0);
    sweep("blank version", 32'h0000_0066);
    reportEnabled <= 1'b1;
    setup(1'b0, 4'hf, 16'h0, 1'b0, 20'hfffff);
    sweep("no support", 32'h0000_001e);
    print_verdict();
  end
endmodule
